// [common/lcfs_defs.svh]
// Timing, reset and register-offset constants for the LED channel fault supervisor.
// Assumes a single free-running system clock whose rate is given below.
`ifndef LCFS_DEFS_SVH
`define LCFS_DEFS_SVH
`define LCFS_MCLK_HZ         20000000
`define LCFS_RETRY_PERIOD_MS 10
`define LCFS_RETRY_PULSE_US  300
`define LCFS_SLS_DEG_US      10
`define LCFS_REG_CTRL        4'h0
`define LCFS_REG_STAT        4'h4
`define LCFS_CTRL_RST        32'h0000000E
`endif

// [common/lcfs_pkg.sv]
// Types shared by the LED channel fault supervisor modules.
// Assumes nothing beyond a SystemVerilog compiler.
package lcfs_pkg;
    typedef enum logic [2:0] {
        LCFS_RUN = 3'b001,
        LCFS_DEG = 3'b010,
        LCFS_FLT = 3'b100
    } lcfs_chst_t;

    typedef struct packed {
        logic [2:0] dim;
        logic [2:0] sls_below;
        logic [2:0] sls_above;
        logic [2:0] open_det;
        logic [2:0] sg_det;
        logic       diag_hi;
        logic       diag_lo;
        logic       temp_hot;
        logic       temp_cool;
        logic       line_lo;
        logic       line_hi;
    } lcfs_cmp_t;

    typedef struct packed {
        logic [27:0] rsvd;
        logic [2:0]  ch_allow;
        logic        sw_off;
    } lcfs_ctrl_t;

    typedef struct packed {
        logic [21:0] rsvd;
        logic [2:0]  drive_en;
        logic        fault_drv;
        logic        diag_on;
        logic        ext_off;
        logic        tsd;
        logic [2:0]  sls_fault;
    } lcfs_stat_t;
endpackage

// [core/lcfs_chan.sv]
// One channel: single-short deglitch, fault hold and periodic retry.
// Assumes its comparator inputs are already synchronised to mclk.
`timescale 1ns/1ps
`default_nettype none
module lcfs_chan #(
    parameter int unsigned DEG_CYC    = 200,
    parameter int unsigned PERIOD_CYC = 200000,
    parameter int unsigned PULSE_CYC  = 6000
) (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic dim,
    input  wire logic mon_en,
    input  wire logic gbl_off,
    input  wire logic below_fall,
    input  wire logic above_rise,
    output logic      cur_en_r,
    output logic      sls_fault
);
    localparam int unsigned CW = $clog2(PERIOD_CYC + 1);
    lcfs_pkg::lcfs_chst_t st_r;
    logic [CW-1:0] deg_cnt_r;
    logic [CW-1:0] ret_cnt_r;
    logic          mon;
    logic          win;

    assign mon = mon_en && dim;
    assign win = (st_r == lcfs_pkg::LCFS_FLT) && (ret_cnt_r < CW'(PULSE_CYC)) && dim && !gbl_off;
    assign sls_fault = (st_r == lcfs_pkg::LCFS_FLT);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= lcfs_pkg::LCFS_RUN;
        end else begin
            case (st_r)
                lcfs_pkg::LCFS_RUN: begin
                    if (mon && below_fall) st_r <= lcfs_pkg::LCFS_DEG;
                end
                lcfs_pkg::LCFS_DEG: begin
                    if (above_rise || !mon) st_r <= lcfs_pkg::LCFS_RUN;
                    else if (deg_cnt_r == CW'(DEG_CYC - 1)) st_r <= lcfs_pkg::LCFS_FLT;
                end
                lcfs_pkg::LCFS_FLT: begin
                    if (win && above_rise) st_r <= lcfs_pkg::LCFS_RUN;
                end
                default: st_r <= lcfs_pkg::LCFS_RUN;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || st_r != lcfs_pkg::LCFS_DEG || above_rise || !mon) deg_cnt_r <= '0;
        else deg_cnt_r <= deg_cnt_r + 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || st_r != lcfs_pkg::LCFS_FLT) ret_cnt_r <= '0;
        else if (ret_cnt_r == CW'(PERIOD_CYC - 1)) ret_cnt_r <= '0;
        else ret_cnt_r <= ret_cnt_r + 1'b1;
    end

    // In fault the channel only conducts inside a retry window.
    always_ff @(posedge mclk) begin
        if (sys_rst) cur_en_r <= 1'b0;
        else cur_en_r <= sls_fault ? win : (dim && !gbl_off);
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_deg_done;
        $rose(sls_fault) |-> $past(st_r == lcfs_pkg::LCFS_DEG) && $past(deg_cnt_r) == CW'(DEG_CYC - 1);
    endproperty
    a_deg_done: assert property (p_deg_done) else $error("short fault before deglitch end");
    property p_deg_rst;
        st_r == lcfs_pkg::LCFS_DEG && above_rise |=> st_r == lcfs_pkg::LCFS_RUN && deg_cnt_r == '0;
    endproperty
    a_deg_rst: assert property (p_deg_rst) else $error("deglitch timer not reset");
    property p_flt_off;
        sls_fault && !win |=> !cur_en_r;
    endproperty
    a_flt_off: assert property (p_flt_off) else $error("faulty channel conducts");
    property p_pulse_dim;
        sls_fault && cur_en_r |-> $past(dim) && $past(ret_cnt_r) < CW'(PULSE_CYC);
    endproperty
    a_pulse_dim: assert property (p_pulse_dim) else $error("retry pulse outside window");
    property p_recover;
        win && above_rise |=> !sls_fault;
    endproperty
    a_recover: assert property (p_recover) else $error("retry did not clear fault");
    property p_mon_off;
        st_r == lcfs_pkg::LCFS_RUN && !mon |=> st_r == lcfs_pkg::LCFS_RUN;
    endproperty
    a_mon_off: assert property (p_mon_off) else $error("monitor active while disabled");
    c_recover: cover property (win && above_rise);
endmodule
`default_nettype wire

// [core/lcfs_top.sv]
// Fault supervisor for three LED channels with thermal and shared fault line handling.
// Assumes comparator results arrive asynchronously and an Avalon-MM master on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "lcfs_defs.svh"
module lcfs_top #(
    parameter int unsigned NCH        = 3,
    parameter int unsigned SLS_DEG_US = `LCFS_SLS_DEG_US,
    parameter int unsigned DEG_CYC    = (SLS_DEG_US * (`LCFS_MCLK_HZ / 1000) + 999) / 1000,
    parameter int unsigned PERIOD_CYC = `LCFS_RETRY_PERIOD_MS * (`LCFS_MCLK_HZ / 1000),
    parameter int unsigned PULSE_CYC  = `LCFS_RETRY_PULSE_US * (`LCFS_MCLK_HZ / 1000) / 1000
) (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire lcfs_pkg::lcfs_cmp_t cmp_in,
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    output logic [2:0]             channel_drive_en,
    output logic                   fault_line_o,
    output logic                   fault_line_oe,
    output logic                   fault_pullup_en
);
    lcfs_pkg::lcfs_cmp_t  s1_r;
    lcfs_pkg::lcfs_cmp_t  s2_r;
    lcfs_pkg::lcfs_ctrl_t ctrl_r;
    lcfs_pkg::lcfs_stat_t stat;
    logic                 diag_on_r;
    logic                 tsd_r;
    logic                 ext_off_r;
    logic                 fault_oe_r;
    logic                 ack_r;
    logic [31:0]          rdata_r;
    logic                 gbl_off;
    logic                 own_fault;
    logic [2:0]           dim_eff;
    logic [2:0]           sls_vec;
    logic [2:0]           open_vec;
    logic                 oe_d1_r;
    logic                 oe_d2_r;
    logic                 own_pull;

    // Two-stage synchroniser for every comparator and pin level.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= cmp_in;
            s2_r <= s1_r;
        end
    end

    // Diagnostic enable with hysteresis between the two comparator levels.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            diag_on_r <= 1'b0;
        end else if (s2_r.diag_hi) begin
            diag_on_r <= 1'b1;
        end else if (s2_r.diag_lo) begin
            diag_on_r <= 1'b0;
        end
    end

    // Thermal shutdown latch released only at the lower recovery level.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tsd_r <= 1'b0;
        end else if (s2_r.temp_hot) begin
            tsd_r <= 1'b1;
        end else if (s2_r.temp_cool) begin
            tsd_r <= 1'b0;
        end
    end

    // A low line that this device is not pulling comes from another driver.
    // Our own pull-down is excluded so that retries stay possible.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ext_off_r <= 1'b0;
        end else if (s2_r.line_lo && !own_pull) begin
            ext_off_r <= 1'b1;
        end else if (s2_r.line_hi) begin
            ext_off_r <= 1'b0;
        end
    end

    assign gbl_off = tsd_r || ext_off_r || ctrl_r.sw_off;
    assign dim_eff = s2_r.dim & ctrl_r.ch_allow;
    assign open_vec = s2_r.open_det & dim_eff & {3{diag_on_r && !gbl_off}};

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
            lcfs_chan #(
                .DEG_CYC    (DEG_CYC),
                .PERIOD_CYC (PERIOD_CYC),
                .PULSE_CYC  (PULSE_CYC)
            ) u_chan (
                .mclk       (mclk),
                .sys_rst    (sys_rst),
                .dim        (dim_eff[gi]),
                .mon_en     (diag_on_r && !gbl_off),
                .gbl_off    (gbl_off),
                .below_fall (s2_r.sls_below[gi]),
                .above_rise (s2_r.sls_above[gi]),
                .cur_en_r   (channel_drive_en[gi]),
                .sls_fault  (sls_vec[gi])
            );
        end
    endgenerate

    // Ground shorts and temperature report whatever the diag enable level.
    assign own_fault = (|sls_vec) || (|open_vec) || (|s2_r.sg_det) || tsd_r;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fault_oe_r <= 1'b0;
        end else begin
            fault_oe_r <= own_fault;
        end
    end

    // Line levels arrive two edges late, so our own pull-down stays masked until it has flushed out.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            oe_d1_r <= 1'b0;
            oe_d2_r <= 1'b0;
        end else begin
            oe_d1_r <= fault_oe_r;
            oe_d2_r <= oe_d1_r;
        end
    end

    assign own_pull = fault_oe_r || oe_d1_r || oe_d2_r;

    assign fault_line_o = 1'b0;
    assign fault_line_oe = fault_oe_r;
    assign fault_pullup_en = !fault_oe_r;

    // Avalon-MM slave: every access waits exactly one cycle.
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign avs_readdata = rdata_r;

    always_comb begin
        stat = '0;
        stat.drive_en = channel_drive_en;
        stat.fault_drv = fault_oe_r;
        stat.diag_on = diag_on_r;
        stat.ext_off = ext_off_r;
        stat.tsd = tsd_r;
        stat.sls_fault = sls_vec;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_r <= `LCFS_CTRL_RST;
        end else if (avs_write && ack_r && avs_address == `LCFS_REG_CTRL) begin
            ctrl_r <= avs_writedata;
            ctrl_r.rsvd <= '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else if (avs_read && !ack_r) begin
            case (avs_address)
                `LCFS_REG_CTRL: begin
                    rdata_r <= ctrl_r;
                end
                `LCFS_REG_STAT: begin
                    rdata_r <= stat;
                end
                default: begin
                    rdata_r <= '0;
                end
            endcase
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_tsd_off;
        tsd_r && $past(tsd_r) |-> channel_drive_en == '0;
    endproperty
    a_tsd_off: assert property (p_tsd_off) else $error("output on in thermal shutdown");

    property p_tsd_hold;
        tsd_r && !s2_r.temp_cool |=> tsd_r;
    endproperty
    a_tsd_hold: assert property (p_tsd_hold) else $error("thermal shutdown released early");

    property p_tsd_line;
        tsd_r |=> fault_line_oe ##0 !fault_pullup_en;
    endproperty
    a_tsd_line: assert property (p_tsd_line) else $error("line not low in shutdown");

    property p_pullup;
        !$past(own_fault) |-> fault_pullup_en && !fault_line_oe;
    endproperty
    a_pullup: assert property (p_pullup) else $error("line not weakly pulled up");

    property p_report;
        (|sls_vec) || (|open_vec) |=> fault_line_oe && fault_line_o == 1'b0;
    endproperty
    a_report: assert property (p_report) else $error("fault not reported on line");

    property p_sg_report;
        (|s2_r.sg_det) && !diag_on_r |=> fault_line_oe;
    endproperty
    a_sg_report: assert property (p_sg_report) else $error("ground short not reported");

    property p_ext_off;
        s2_r.line_lo && !own_pull |=> ##1 channel_drive_en == '0;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("outputs on with line low");

    property p_ext_hold;
        ext_off_r && !s2_r.line_hi |=> ext_off_r;
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("external off released early");

    property p_diag_off;
        !diag_on_r && sls_vec == '0 |=> sls_vec == '0;
    endproperty
    a_diag_off: assert property (p_diag_off) else $error("short flagged with diag off");

    property p_diag_on;
        $rose(diag_on_r) |-> $past(s2_r.diag_hi);
    endproperty
    a_diag_on: assert property (p_diag_on) else $error("diag on without high level");

    property p_dim_off;
        !dim_eff[0] && !sls_vec[0] |=> !channel_drive_en[0];
    endproperty
    a_dim_off: assert property (p_dim_off) else $error("channel on with dimming low");

    property p_bus_wait;
        (avs_read || avs_write) && !ack_r |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus answer not after one cycle");

    property p_ext_set;
        $rose(ext_off_r) |-> $past(s2_r.line_lo) && !$past(own_pull);
    endproperty
    a_ext_set: assert property (p_ext_set) else $error("external off without foreign low line");

    property p_ext_clear;
        $fell(ext_off_r) |-> $past(s2_r.line_hi);
    endproperty
    a_ext_clear: assert property (p_ext_clear) else $error("external off cleared without high line");

    property p_tsd_set;
        s2_r.temp_hot |=> tsd_r;
    endproperty
    a_tsd_set: assert property (p_tsd_set) else $error("hot level did not shut down");

    property p_tsd_clear;
        $fell(tsd_r) |-> $past(s2_r.temp_cool) && !$past(s2_r.temp_hot);
    endproperty
    a_tsd_clear: assert property (p_tsd_clear) else $error("shutdown left above recovery level");

    property p_diag_keep;
        diag_on_r && !s2_r.diag_lo |=> diag_on_r;
    endproperty
    a_diag_keep: assert property (p_diag_keep) else $error("diag dropped without low level");

    property p_diag_drop;
        s2_r.diag_lo && !s2_r.diag_hi |=> !diag_on_r;
    endproperty
    a_diag_drop: assert property (p_diag_drop) else $error("diag kept with low level");

    property p_line_drop;
        !own_fault |=> !fault_line_oe && fault_pullup_en;
    endproperty
    a_line_drop: assert property (p_line_drop) else $error("line pulled low with no fault");

    property p_line_set;
        own_fault |=> fault_line_oe && !fault_pullup_en;
    endproperty
    a_line_set: assert property (p_line_set) else $error("own fault not driven on line");

    property p_dim_off2;
        !dim_eff[2] && !sls_vec[2] |=> !channel_drive_en[2];
    endproperty
    a_dim_off2: assert property (p_dim_off2) else $error("third channel on with dimming low");

    property p_sw_off;
        ctrl_r.sw_off && $past(ctrl_r.sw_off) |-> channel_drive_en == '0;
    endproperty
    a_sw_off: assert property (p_sw_off) else $error("outputs on while switched off");

    property p_unmapped;
        avs_read && !ack_r && avs_address != `LCFS_REG_CTRL && avs_address != `LCFS_REG_STAT
            |=> avs_readdata == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    c_tsd: cover property ($rose(tsd_r));
    c_ext: cover property ($rose(ext_off_r));
    c_flt: cover property ($rose(|sls_vec));
    c_clr: cover property ($fell(|sls_vec));
endmodule
`default_nettype wire

// [tb/lcfs_line_model.sv]
// Model of the other drivers that share the fault line with this supervisor.
// Assumes the supervisor's own weak pull-up is what lifts a line that nobody pulls down.
`timescale 1ns/1ps
`default_nettype none
module lcfs_line_model (
    input  wire logic       fault_line_o,
    input  wire logic       fault_line_oe,
    input  wire logic       fault_pullup_en,
    input  wire logic [1:0] other_mode,
    output logic            line_lo,
    output logic            line_hi
);
    // Mode 1 pulls the line low, mode 2 leaves it between the two thresholds.
    always_comb begin
        if ((fault_line_oe && !fault_line_o) || other_mode == 2'h1) begin
            line_lo = 1'b1;
            line_hi = 1'b0;
        end else if (other_mode == 2'h2) begin
            line_lo = 1'b0;
            line_hi = 1'b0;
        end else begin
            line_lo = 1'b0;
            line_hi = fault_pullup_en;
        end
    end
endmodule
`default_nettype wire

// [tb/tb_lcfs_top.sv]
// Self-checking bench for the LED channel fault supervisor.
// Assumes lcfs_top, lcfs_pkg and the line model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_lcfs_top;
    localparam int DEG = 20;
    localparam int PER = 100;
    localparam int PUL = 10;
    logic                mclk;
    logic                sys_rst;
    lcfs_pkg::lcfs_cmp_t cmp_r;
    lcfs_pkg::lcfs_cmp_t cmp_in;
    logic [3:0]          avs_address;
    logic                avs_read;
    logic                avs_write;
    logic [31:0]         avs_writedata;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    logic [2:0]          channel_drive_en;
    logic                fault_line_o;
    logic                fault_line_oe;
    logic                fault_pullup_en;
    logic [1:0]          other_mode;
    logic                line_lo;
    logic                line_hi;
    logic [31:0]         expq[$];
    int                  failures;
    int                  total_checks;
    int                  cyc;
    int                  seed;
    int                  g;
    int                  hi;
    int                  per;

    lcfs_top #(.DEG_CYC(DEG), .PERIOD_CYC(PER), .PULSE_CYC(PUL)) u_lcfs_top (
        .mclk(mclk), .sys_rst(sys_rst), .cmp_in(cmp_in), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .channel_drive_en(channel_drive_en), .fault_line_o(fault_line_o),
        .fault_line_oe(fault_line_oe), .fault_pullup_en(fault_pullup_en));

    lcfs_line_model u_lcfs_line_model (
        .fault_line_o(fault_line_o), .fault_line_oe(fault_line_oe), .fault_pullup_en(fault_pullup_en),
        .other_mode(other_mode), .line_lo(line_lo), .line_hi(line_hi));

    always_comb begin
        cmp_in = cmp_r;
        cmp_in.line_lo = line_lo;
        cmp_in.line_hi = line_hi;
    end

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc > 5000) begin
            failures++;
            report_and_stop();
        end
    end

    // Each completed read takes the oldest expected word off the queue.
    always @(posedge mclk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (expq.size() == 0) begin
                failures++;
                $display("wrong value readdata expected none seen %h", avs_readdata);
            end else begin
                check("readdata", expq.pop_front(), avs_readdata);
            end
        end
    end

    task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        bus(1'b1, a, 32'h0);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask

    function automatic logic [31:0] st(input logic [2:0] sls, input logic t, input logic e,
                                       input logic d, input logic f, input logic [2:0] drv);
        return {22'h0, drv, f, d, e, t, sls};
    endfunction

    task automatic pulse(output int h, output int p);
        int n;
        n = 0;
        while (channel_drive_en[0] !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        h = 0;
        while (channel_drive_en[0] === 1'b1 && h < 400) begin
            @(posedge mclk);
            h++;
        end
        p = h;
        while (channel_drive_en[0] !== 1'b1 && p < 400) begin
            @(posedge mclk);
            p++;
        end
    endtask

    initial begin
        failures = 0;
        total_checks = 0;
        cyc = 0;
        seed = 32'hc238e276;
        sys_rst = 1'b1;
        cmp_r = '0;
        cmp_r.diag_hi = 1'b1;
        cmp_r.temp_cool = 1'b1;
        other_mode = 2'h0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        wt(2);
        sys_rst <= 1'b0;
        wt(4);
        rd(4'h0, 32'h0000000E);
        rd(4'h4, st(3'h0, 0, 0, 1, 0, 3'h0));
        bus(1'b0, 4'h4, 32'hFFFFFFFF);
        bus(1'b0, 4'h0, 32'hFFFFFFFE);
        rd(4'h0, 32'h0000000E);
        rd(4'h8, 32'h00000000);
        cmp_r.dim <= 3'h7;
        wt(8);
        rd(4'h4, st(3'h0, 0, 0, 1, 0, 3'h7));
        bus(1'b0, 4'h0, 32'h0000000C);
        wt(6);
        rd(4'h4, st(3'h0, 0, 0, 1, 0, 3'h6));
        bus(1'b0, 4'h0, 32'h00000001);
        wt(6);
        rd(4'h4, st(3'h0, 0, 0, 1, 0, 3'h0));
        bus(1'b0, 4'h0, 32'h0000000E);
        cmp_r.dim <= 3'h5;
        cmp_r.sls_below <= 3'h2;
        wt(DEG * 2);
        rd(4'h4, st(3'h0, 0, 0, 1, 0, 3'h5));
        cmp_r.dim <= 3'h7;
        cmp_r.diag_hi <= 1'b0;
        cmp_r.diag_lo <= 1'b1;
        cmp_r.sls_below <= 3'h4;
        cmp_r.open_det <= 3'h3;
        wt(DEG * 2);
        rd(4'h4, st(3'h0, 0, 0, 0, 0, 3'h7));
        cmp_r.sg_det <= 3'h1;
        wt(8);
        rd(4'h4, st(3'h0, 0, 0, 0, 1, 3'h7));
        cmp_r.sg_det <= 3'h0;
        cmp_r.temp_hot <= 1'b1;
        cmp_r.temp_cool <= 1'b0;
        wt(8);
        rd(4'h4, st(3'h0, 1, 0, 0, 1, 3'h0));
        check("line_pins", 32'h4, 32'({fault_line_oe, fault_line_o, fault_pullup_en}));
        cmp_r.temp_hot <= 1'b0;
        wt(8);
        rd(4'h4, st(3'h0, 1, 0, 0, 1, 3'h0));
        cmp_r.temp_cool <= 1'b1;
        wt(8);
        rd(4'h4, st(3'h0, 0, 0, 0, 0, 3'h7));
        check("line_pins", 32'h1, 32'({fault_line_oe, fault_line_o, fault_pullup_en}));
        cmp_r.diag_hi <= 1'b1;
        cmp_r.diag_lo <= 1'b0;
        cmp_r.sls_below <= 3'h0;
        cmp_r.open_det <= 3'h0;
        wt(8);
        // A rising-threshold blip inside the deglitch window must restart the timer.
        g = 10 + ($random(seed) & 3);
        cmp_r.sls_below <= 3'h1;
        wt(g);
        cmp_r.sls_above <= 3'h1;
        wt(2);
        cmp_r.sls_above <= 3'h0;
        wt(DEG - 8);
        rd(4'h4, st(3'h0, 0, 0, 1, 0, 3'h7));
        wt(30);
        cmp_r.dim <= 3'h6;
        wt(6);
        rd(4'h4, st(3'h1, 0, 0, 1, 1, 3'h6));
        hi = 0;
        repeat (PER) begin
            @(posedge mclk);
            hi += channel_drive_en[0];
        end
        check("retry_without_dim", 32'(0), 32'(hi));
        cmp_r.dim <= 3'h7;
        pulse(hi, per);
        pulse(hi, per);
        check("retry_width", 32'(PUL), 32'(hi));
        check("retry_period", 32'(PER), 32'(per));
        cmp_r.sls_below <= 3'h0;
        cmp_r.sls_above <= 3'h1;
        wt(PER + 10);
        rd(4'h4, st(3'h0, 0, 0, 1, 0, 3'h7));
        cmp_r.sls_above <= 3'h0;
        other_mode <= 2'h1;
        wt(8);
        rd(4'h4, st(3'h0, 0, 1, 1, 0, 3'h0));
        other_mode <= 2'h2;
        wt(8);
        rd(4'h4, st(3'h0, 0, 1, 1, 0, 3'h0));
        other_mode <= 2'h0;
        wt(8);
        rd(4'h4, st(3'h0, 0, 0, 1, 0, 3'h7));
        wt(4);
        report_and_stop();
    end
endmodule
`default_nettype wire
